/* File: asc_defines.svh */
// What this block does
// - read after conversion: busy low, selects low, 18 bits out MSB first
// - result clock may run at any rate up to 40 MHz
// - chain input sampled on the edge opposite the shift edge
// - cascaded upstream bits follow the local LSB on the output
// - read during conversion: previous result out, 18 bits MSB first
// - read during conversion: error pulses if 18 bits not read before conversion ends
// - a read may start after and finish during the next conversion
// - pin configuration used in parallel modes or with pin select high
// - with port configuration the configuration pins are ignored
// - config port active only when mode is 3 and pin select low
// - config bits enter MSB first; bit 8 is the start bit
// - the ninth config clock edge loads the active configuration
// - the two lowest config bits are reserved and never written
// - config port accepts writes at any time up to 40 MHz
// - config port works in every serial read arrangement
// - reset clears every configuration bit to zero
// - a high start bit is needed for the word to load
// - power-down leaves the config port usable
// - bits 4 and 3 select normal, warp, impulse, normal
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_RES_W 18
`define ASC_RES_BITS 5'h12
`define ASC_FIFO_DEPTH 8
`define ASC_SYNC_W 18
`define ASC_SERIAL_MODE 2'h3
`define ASC_CFG_W 9
`define ASC_CFG_LAST 4'h8
`define ASC_CFG_RESET 9'h000
`define ASC_CFG_START 8
`define ASC_CFG_BIPOLAR 7
`define ASC_CFG_WIDE 6
`define ASC_CFG_PD 5
`define ASC_CFG_IMPULSE 4
`define ASC_CFG_WARP 3
`define ASC_CFG_CODING 2
`endif

/* File: asc_pkg.sv */
`default_nettype none
package asc_pkg;
  typedef enum logic [1:0] {
    ASC_SPEED_NORMAL,
    ASC_SPEED_IMPULSE,
    ASC_SPEED_WARP
  } asc_speed_t;
  typedef enum logic {
    ASC_RD_IDLE,
    ASC_RD_SHIFT
  } asc_rd_state_t;
endpackage : asc_pkg
`default_nettype wire

/* File: asc_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface asc_stream_if #(parameter int W = 18);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : asc_stream_if
`default_nettype wire

/* File: asc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module asc_fifo #(
  parameter int W = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  asc_stream_if.snk inIf,
  asc_stream_if.src outIf
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic inReady_reg;
  logic push;
  logic pop;

  // ready kept in a flop so the top port comes straight from a register
  assign push = inIf.valid & inReady_reg;
  assign pop = outIf.ready & (count_reg != '0);
  assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign inIf.ready = inReady_reg;
  assign outIf.valid = (count_reg != '0);
  assign outIf.data = mem[rdPtr_reg];

  // storage has no reset; only pointers and count matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inIf.data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady_reg <= 1'b1;
    end else begin
      wrPtr_reg <= push ? wrPtr_reg + AW'(1) : wrPtr_reg;
      rdPtr_reg <= pop ? rdPtr_reg + AW'(1) : rdPtr_reg;
      count_reg <= count_next;
      inReady_reg <= (count_next != FULL);
    end
  end

  default clocking fcb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_fifo_bounded: assert property (
    count_reg <= FULL && (inReady_reg == (count_reg != FULL)))
    else $error("fifo count or ready out of step");
endmodule : asc_fifo
`default_nettype wire

/* File: asc_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"
module asc_port (
  input wire logic clk,
  input wire logic srst,
  input wire logic serialResultClock,
  input wire logic resultSelectN,
  input wire logic readStrobeN,
  input wire logic chainInput,
  input wire logic clockInvertSelect,
  input wire logic readDuringConversion,
  input wire logic [1:0] interfaceMode,
  input wire logic pinOrPortConfigSelect,
  input wire logic configPortSelectN,
  input wire logic configSerialIn,
  input wire logic configSerialClock,
  input wire logic hwBipolar,
  input wire logic hwWideRangeBit,
  input wire logic hwPowerDownBit,
  input wire logic hwWarp,
  input wire logic hwImpulse,
  input wire logic hwOutputCodingSelect,
  input wire logic convBusy,
  input wire logic [`ASC_RES_W-1:0] resultData,
  input wire logic resultValid,
  output logic resultReady,
  output logic serialResultOut,
  output logic serialResultOutEnN,
  output logic readErrorFlag,
  output logic rangeBipolar,
  output logic rangeWide,
  output logic powerDown,
  output var asc_pkg::asc_speed_t speedMode,
  output logic outputCodingSelect,
  output logic configFromPort
);
  import asc_pkg::*;

  // impulse alone, warp alone, anything else is normal
  function automatic asc_speed_t speedDecode(
    input logic warp,
    input logic imp
  );
    if (warp == imp) begin
      return ASC_SPEED_NORMAL;
    end else if (imp) begin
      return ASC_SPEED_IMPULSE;
    end else begin
      return ASC_SPEED_WARP;
    end
  endfunction : speedDecode

  // active edge of a sampled clock; inv picks falling
  function automatic logic edgeSel(
    input logic inv,
    input logic cur,
    input logic prev
  );
    return inv ? (~cur & prev) : (cur & ~prev);
  endfunction : edgeSel

  // core result is twos complement; straight binary flips the msb
  function automatic logic [`ASC_RES_W-1:0] codeConvert(
    input logic [`ASC_RES_W-1:0] word,
    input logic straight
  );
    return {word[`ASC_RES_W-1] ^ straight, word[`ASC_RES_W-2:0]};
  endfunction : codeConvert

  // all pins are asynchronous to clk
  logic [`ASC_SYNC_W-1:0] syncIn;
  logic [`ASC_SYNC_W-1:0] syncA_reg;
  logic [`ASC_SYNC_W-1:0] syncB_reg;
  logic sClkPrev_reg;
  logic cClkPrev_reg;
  logic busyPrev_reg;
  logic sClk;
  logic sChain;
  logic sSelN;
  logic sRdN;
  logic sInv;
  logic sRdc;
  logic [1:0] sMode;
  logic sHwSw;
  logic sCfgSelN;
  logic sCfgIn;
  logic sCfgClk;
  logic sBip;
  logic sWide;
  logic sPd;
  logic sWarp;
  logic sImp;
  logic sCoding;

  assign syncIn = {serialResultClock, chainInput, resultSelectN,
    readStrobeN, clockInvertSelect, readDuringConversion, interfaceMode,
    pinOrPortConfigSelect, configPortSelectN, configSerialIn,
    configSerialClock, hwBipolar, hwWideRangeBit, hwPowerDownBit, hwWarp,
    hwImpulse, hwOutputCodingSelect};
  assign {sClk, sChain, sSelN, sRdN, sInv, sRdc, sMode, sHwSw, sCfgSelN,
    sCfgIn, sCfgClk, sBip, sWide, sPd, sWarp, sImp, sCoding} = syncB_reg;

  // two-stage synchroniser; pin edges are found on the second stage, the busy edge on convBusy itself
  always_ff @(posedge clk) begin
    if (srst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      sClkPrev_reg <= 1'b0;
      cClkPrev_reg <= 1'b0;
      busyPrev_reg <= 1'b0;
    end else begin
      syncA_reg <= syncIn;
      syncB_reg <= syncA_reg;
      sClkPrev_reg <= sClk;
      cClkPrev_reg <= sCfgClk;
      busyPrev_reg <= convBusy;
    end
  end

  // result buffer between the conversion core and the serial reader
  asc_stream_if #(.W(`ASC_RES_W)) inIf ();
  asc_stream_if #(.W(`ASC_RES_W)) outIf ();

  assign inIf.valid = resultValid;
  assign inIf.data = resultData;
  assign resultReady = inIf.ready;

  asc_fifo #(
    .W(`ASC_RES_W),
    .DEPTH(`ASC_FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .srst(srst),
    .inIf(inIf),
    .outIf(outIf)
  );

  // result read decode
  asc_rd_state_t rdState_reg;
  asc_rd_state_t rdState_next;
  logic [`ASC_RES_W-1:0] shReg_reg;
  logic [`ASC_RES_W-1:0] shReg_next;
  logic [4:0] bitCnt_reg;
  logic [4:0] bitCnt_next;
  logic duringRead_reg;
  logic out_next;
  logic readErr_next;
  logic [`ASC_RES_W-1:0] loadWord;
  logic readSel;
  logic startRead;
  logic inShift;
  logic shiftEdge;
  logic latchEdge;
  logic busyFell;
  logic bitsLeft;

  assign readSel = ~sSelN & ~sRdN & (sMode == `ASC_SERIAL_MODE);
  assign inShift = (rdState_reg == ASC_RD_SHIFT);
  // after-mode waits for idle, during-mode needs a running conversion
  assign startRead = ~inShift & readSel &
    (sRdc ? convBusy : ~convBusy);
  assign shiftEdge = inShift & edgeSel(sInv, sClk, sClkPrev_reg);
  // chain bits only once a shift has freed a slot, so an opposite edge
  // ahead of the first shift (either idle level) is ignored
  assign latchEdge = inShift & (bitCnt_reg != 5'h00) &
    edgeSel(~sInv, sClk, sClkPrev_reg);
  assign busyFell = busyPrev_reg & ~convBusy;
  assign bitsLeft = (bitCnt_reg < `ASC_RES_BITS);
  // an empty buffer loads zero ahead of the code conversion rather than stale data
  assign loadWord = codeConvert(outIf.valid ? outIf.data : '0,
    outputCodingSelect);
  assign outIf.ready = startRead;

  // a read begun while idle may run on into the next conversion
  assign rdState_next = startRead ? ASC_RD_SHIFT :
    (inShift & readSel) ? ASC_RD_SHIFT : ASC_RD_IDLE;
  // the slot freed by each shift sits at bit 1; bit 0 stays empty so
  // the upstream msb follows the local lsb with no gap bit
  assign shReg_next = startRead ? {loadWord[`ASC_RES_W-2:0], 1'b0} :
    shiftEdge ? {shReg_reg[`ASC_RES_W-2:0], 1'b0} :
    latchEdge ? {shReg_reg[`ASC_RES_W-1:2], sChain, 1'b0} :
    shReg_reg;
  assign out_next = startRead ? loadWord[`ASC_RES_W-1] :
    shiftEdge ? shReg_reg[`ASC_RES_W-1] : serialResultOut;
  // the count saturates; chain bits keep flowing past it
  assign bitCnt_next = startRead ? 5'h00 :
    (shiftEdge & bitsLeft) ? bitCnt_reg + 5'h01 : bitCnt_reg;
  assign readErr_next = inShift & duringRead_reg & bitsLeft &
    busyFell;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdState_reg <= ASC_RD_IDLE;
      shReg_reg <= '0;
      bitCnt_reg <= 5'h00;
      duringRead_reg <= 1'b0;
      serialResultOut <= 1'b0;
      serialResultOutEnN <= 1'b1;
      readErrorFlag <= 1'b0;
    end else begin
      rdState_reg <= rdState_next;
      shReg_reg <= shReg_next;
      bitCnt_reg <= bitCnt_next;
      duringRead_reg <= startRead ? sRdc : duringRead_reg;
      serialResultOut <= out_next;
      serialResultOutEnN <= (rdState_next != ASC_RD_SHIFT);
      readErrorFlag <= readErr_next;
    end
  end

  // configuration port decode
  logic [`ASC_CFG_W-1:0] cfgReg_reg;
  logic [`ASC_CFG_W-1:0] cfgReg_next;
  logic [`ASC_CFG_W-2:0] cfgShift_reg;
  logic [`ASC_CFG_W-2:0] cfgShift_next;
  logic [3:0] cfgCnt_reg;
  logic [3:0] cfgCnt_next;
  logic [`ASC_CFG_W-1:0] cfgWord;
  logic cfgActive;
  logic cfgTake;
  logic cfgLoad;
  logic hwCfg;

  // independent of the read path, so any read timing keeps it usable
  assign cfgActive = (sMode == `ASC_SERIAL_MODE) & ~sHwSw;
  assign cfgTake = cfgActive & ~sCfgSelN &
    edgeSel(sInv, sCfgClk, cClkPrev_reg);
  assign cfgWord = {cfgShift_reg, sCfgIn};
  // a low start bit leaves the active word alone
  assign cfgLoad = cfgTake & (cfgCnt_reg == `ASC_CFG_LAST) &
    cfgWord[`ASC_CFG_START];
  // deselect or leaving port mode throws the partial word away
  assign cfgCnt_next = (~cfgActive | sCfgSelN) ? 4'h0 :
    ~cfgTake ? cfgCnt_reg :
    (cfgCnt_reg == `ASC_CFG_LAST) ? 4'h0 : cfgCnt_reg + 4'h1;
  assign cfgShift_next = cfgTake ?
    {cfgShift_reg[`ASC_CFG_W-3:0], sCfgIn} : cfgShift_reg;
  // reserved low bits are carried over, never taken from the wire
  assign cfgReg_next = cfgLoad ?
    {cfgWord[`ASC_CFG_W-1:2], cfgReg_reg[1:0]} : cfgReg_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      cfgReg_reg <= `ASC_CFG_RESET;
      cfgShift_reg <= '0;
      cfgCnt_reg <= 4'h0;
    end else begin
      cfgReg_reg <= cfgReg_next;
      cfgShift_reg <= cfgShift_next;
      cfgCnt_reg <= cfgCnt_next;
    end
  end

  // effective setting: pins unless the port owns the configuration
  logic bip_next;
  logic wide_next;
  logic pd_next;
  logic coding_next;
  asc_speed_t speed_next;

  assign hwCfg = ~cfgActive;
  assign bip_next = hwCfg ? sBip : cfgReg_reg[`ASC_CFG_BIPOLAR];
  assign wide_next = hwCfg ? sWide : cfgReg_reg[`ASC_CFG_WIDE];
  // power-down gates only the converter; the port keeps listening
  assign pd_next = hwCfg ? sPd : cfgReg_reg[`ASC_CFG_PD];
  assign coding_next = hwCfg ? sCoding : cfgReg_reg[`ASC_CFG_CODING];
  assign speed_next = hwCfg ? speedDecode(sWarp, sImp) :
    speedDecode(cfgReg_reg[`ASC_CFG_WARP],
    cfgReg_reg[`ASC_CFG_IMPULSE]);

  always_ff @(posedge clk) begin
    if (srst) begin
      rangeBipolar <= 1'b0;
      rangeWide <= 1'b0;
      powerDown <= 1'b0;
      outputCodingSelect <= 1'b0;
      speedMode <= ASC_SPEED_NORMAL;
      configFromPort <= 1'b0;
    end else begin
      rangeBipolar <= bip_next;
      rangeWide <= wide_next;
      powerDown <= pd_next;
      outputCodingSelect <= coding_next;
      speedMode <= speed_next;
      configFromPort <= cfgActive;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_msb_first: assert property (
    startRead |=> serialResultOut == $past(loadWord[`ASC_RES_W-1]) &&
      !serialResultOutEnN)
    else $error("result msb not presented at read start");

  a_after_idle: assert property (
    (startRead && !sRdc) |-> !convBusy)
    else $error("after-mode read started during conversion");

  a_during_busy: assert property (
    (startRead && sRdc) |-> convBusy)
    else $error("during-mode read started while idle");

  a_bit_count: assert property (
    (shiftEdge && bitsLeft) |=> bitCnt_reg == $past(bitCnt_reg) + 5'h01)
    else $error("result bit count did not advance");

  a_err_pulse: assert property (
    (inShift && duringRead_reg && bitsLeft && busyFell) |=>
      readErrorFlag ##1 !readErrorFlag)
    else $error("read error not a single pulse");

  a_chain_latch: assert property (
    latchEdge |=> shReg_reg[1] == $past(sChain))
    else $error("chain bit not latched on opposite edge");

  a_chain_follow: assert property (
    shiftEdge |=> serialResultOut == $past(shReg_reg[`ASC_RES_W-1]))
    else $error("shift edge did not advance the output");

  a_cfg_ninth: assert property (
    cfgLoad |=> cfgReg_reg[`ASC_CFG_W-1:2] == $past(cfgWord[`ASC_CFG_W-1:2]))
    else $error("ninth config edge did not load the word");

  a_cfg_reserved: assert property (
    cfgReg_reg[1:0] == 2'h0)
    else $error("reserved config bits changed");

  a_cfg_abort: assert property (
    sCfgSelN |=> cfgCnt_reg == 4'h0 && $stable(cfgReg_reg))
    else $error("deselected config port kept a partial word");

  a_cfg_gate: assert property (
    !cfgActive |=> $stable(cfgReg_reg))
    else $error("config word changed outside port mode");

  a_pin_config: assert property (
    !cfgActive |=> rangeWide == $past(sWide) && powerDown == $past(sPd))
    else $error("pin configuration not followed");
endmodule : asc_port
`default_nettype wire

/* File: asc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the pins: result reader and config writer, 125 ns link clock
module asc_host_model (
  output logic sclk,
  output logic selN,
  output logic rdN,
  output logic chain,
  output logic cfgSelN,
  output logic cfgClk,
  output logic cfgIn,
  input wire logic sdo
);
  localparam realtime HALF = 62.5;

  // idle levels; clocks stand low outside frames
  initial begin
    sclk = 1'b0;
    selN = 1'b1;
    rdN = 1'b1;
    chain = 1'b0;
    cfgSelN = 1'b1;
    cfgClk = 1'b0;
    cfgIn = 1'b0;
  end

  // sample before each shift edge; 62.5 ns halves leave the 30 ns
  // sampler need and the chain setup well covered
  task automatic read_bits(input int n, input logic c,
                           output logic [19:0] q);
    q = '0;
    chain = c;
    selN = 1'b0;
    rdN = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      q = {q[18:0], sdo};
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
      #HALF;
    end
    selN = 1'b1;
    rdN = 1'b1;
    #100;
  endtask : read_bits

  // n below 9 aborts the word by deselecting early
  task automatic write_cfg(input logic [8:0] w, input int n);
    cfgSelN = 1'b0;
    #HALF;
    for (int i = 8; i > 8 - n; i--) begin
      cfgIn = w[i];
      #HALF;
      cfgClk = 1'b1;
      #HALF;
      cfgClk = 1'b0;
    end
    #100;
    cfgSelN = 1'b1;
    cfgIn = ~cfgIn;
    #100;
  endtask : write_cfg
endmodule : asc_host_model
`default_nettype wire

/* File: adc_slave_serial_read_and_config_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_slave_serial_read_and_config_port_test;
  import asc_pkg::*;
`define CHK(nm, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); \
  end \
end
  logic clk, srst, sclk, selN, rdN, chain, cfgSelN, cfgClk, cfgIn;
  logic rdc, pinSel, busy, valid;
  logic [1:0] mode;
  logic [5:0] hw;
  logic [17:0] data;
  logic [19:0] q;
  wire logic ready, sdo, sdoEnN, rdErr, bip, wide, pd, cod, fromPort;
  asc_speed_t spd;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int errPulses = 0;
  // config word beside expected {bipolar, wide, pd, speed, coding}
  logic [14:0] rows [9] = '{{9'h100, 6'h00}, {9'h180, 6'h20},
    {9'h140, 6'h10}, {9'h120, 6'h08}, {9'h110, 6'h02}, {9'h108, 6'h04},
    {9'h118, 6'h00}, {9'h104, 6'h01}, {9'h1ff, 6'h39}};
  wire logic [5:0] cfgOut = {bip, wide, pd, 2'(spd), cod};

  asc_host_model host (.sclk(sclk), .selN(selN), .rdN(rdN),
    .chain(chain), .cfgSelN(cfgSelN), .cfgClk(cfgClk), .cfgIn(cfgIn),
    .sdo(sdo));

  asc_port dut (.clk(clk), .srst(srst), .serialResultClock(sclk),
    .resultSelectN(selN), .readStrobeN(rdN), .chainInput(chain),
    .clockInvertSelect(1'b0), .readDuringConversion(rdc),
    .interfaceMode(mode), .pinOrPortConfigSelect(pinSel),
    .configPortSelectN(cfgSelN), .configSerialIn(cfgIn),
    .configSerialClock(cfgClk), .hwBipolar(hw[5]),
    .hwWideRangeBit(hw[4]), .hwPowerDownBit(hw[3]), .hwWarp(hw[2]),
    .hwImpulse(hw[1]), .hwOutputCodingSelect(hw[0]), .convBusy(busy),
    .resultData(data), .resultValid(valid), .resultReady(ready),
    .serialResultOut(sdo), .serialResultOutEnN(sdoEnN),
    .readErrorFlag(rdErr), .rangeBipolar(bip), .rangeWide(wide),
    .powerDown(pd), .speedMode(spd), .outputCodingSelect(cod),
    .configFromPort(fromPort));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the few thousand cycles the run needs;
  // counted off the falling clock edge so the error pulse is settled
  always @(negedge clk) begin
    cycles++;
    if (rdErr === 1'b1) errPulses++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task push(input logic [17:0] w);
    @(negedge clk);
    valid = 1'b1;
    data = w;
    @(negedge clk);
    valid = 1'b0;
  endtask : push

  initial begin
    srst = 1'b1;
    rdc = 1'b0;
    pinSel = 1'b0;
    busy = 1'b0;
    valid = 1'b0;
    mode = 2'h3;
    hw = 6'h2d;
    data = 18'h0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    `CHK("reset cfg", 6'h00, cfgOut)
    `CHK("reset enable", 1'b1, sdoEnN)
    `CHK("reset ready", 1'b1, ready)
    repeat (4) @(negedge clk);
    `CHK("port active", 1'b1, fromPort)
    // every field and speed code through the table
    for (int i = 0; i < 9; i++) begin
      host.write_cfg(rows[i][14:6], 9);
      `CHK("cfg row", rows[i][5:0], cfgOut)
    end
    host.write_cfg(9'h000, 9);
    `CHK("start low", 6'h39, cfgOut)
    host.write_cfg(9'h100, 5);
    `CHK("partial word", 6'h39, cfgOut)
    host.write_cfg(9'h120, 9);
    `CHK("power down", 6'h08, cfgOut)
    // pins rule when the port is off, and the port ignores writes
    pinSel = 1'b1;
    host.write_cfg(9'h180, 9);
    `CHK("pin cfg", 6'h2d, cfgOut)
    `CHK("pin mode", 1'b0, fromPort)
    pinSel = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("pins ignored", 6'h08, cfgOut)
    mode = 2'h2;
    host.write_cfg(9'h180, 9);
    `CHK("parallel pins", 6'h2d, cfgOut)
    mode = 2'h3;
    host.write_cfg(9'h104, 9);
    // fill until refused, then drain oldest first
    for (int k = 0; k < 8; k++) begin
      push(18'h3c0f0 ^ 18'(k));
    end
    @(negedge clk);
    `CHK("buffer full", 1'b0, ready)
    host.read_bits(18, 1'b0, q);
    `CHK("straight code", 18'h3c0f0 ^ 18'h20000, q[17:0])
    host.write_cfg(9'h100, 9);
    for (int k = 1; k < 6; k++) begin
      host.read_bits(18, 1'b0, q);
      `CHK("read after", 18'h3c0f0 ^ 18'(k), q[17:0])
    end
    // read begun while idle runs on after the next conversion starts
    fork
      host.read_bits(18, 1'b0, q);
      begin
        #1200;
        @(negedge clk);
        busy = 1'b1;
      end
    join
    @(negedge clk);
    busy = 1'b0;
    `CHK("read across", 18'h3c0f6, q[17:0])
    host.read_bits(20, 1'b1, q);
    `CHK("chain pass", {18'h3c0f7, 2'b11}, q)
    // read during conversion, no chain in this timing
    rdc = 1'b1;
    push(18'h2a5c3);
    busy = 1'b1;
    host.read_bits(18, 1'b0, q);
    `CHK("read during", 18'h2a5c3, q[17:0])
    @(negedge clk);
    busy = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("no error", 0, errPulses)
    push(18'h1b4e7);
    busy = 1'b1;
    fork
      host.read_bits(8, 1'b0, q);
      begin
        #600;
        @(negedge clk);
        busy = 1'b0;
      end
    join
    `CHK("partial bits", 8'h6d, q[7:0])
    `CHK("error pulse", 1, errPulses)
    end_sim();
  end
endmodule : adc_slave_serial_read_and_config_port_test
`default_nettype wire
